// ### rtl/ahps_pkg.sv
// Package for the converter host port: constants, state encodings and state struct.
// Assumes a single system clock at the rate given by AHPS_CLK_MHZ.
package ahps_pkg;

  // System clock rate
  localparam int AHPS_CLK_MHZ = 200;

  // Start-up times in microseconds, and their cycle counts
  localparam int AHPS_POR_US        = 250;
  localparam int AHPS_REGACQ_US     = 5;
  localparam int AHPS_POR_CYCLES    = AHPS_POR_US * AHPS_CLK_MHZ;
  localparam int AHPS_REGACQ_CYCLES = AHPS_REGACQ_US * AHPS_CLK_MHZ;

  // Sync/reset pulse limits in master clock periods
  localparam logic [11:0] AHPS_SYNC_MIN   = 12'h001;
  localparam logic [11:0] AHPS_SYNC_MAX   = 12'h7ff;
  localparam logic [11:0] AHPS_RESET_LEN  = 12'h800;

  // Sample-ready phase lengths in master clock periods
  localparam logic [2:0] AHPS_READY_HIGH = 3'h4;
  localparam logic [2:0] AHPS_READY_LOW  = 3'h4;

  // Serial frame timeout in master clock periods
  localparam int AHPS_TIMEOUT_PERIODS = 32768;

  // Serial word width default
  localparam int AHPS_WORD_W = 24;

  // Synchroniser positions: 0 first stage, 1 stable, 2 previous
  localparam int AHPS_SYN_STABLE = 1;
  localparam int AHPS_SYN_PREV   = 2;

  // Sample-ready sequencer states
  typedef enum logic [3:0] {
    AHPS_ST_BOOT = 4'h1,
    AHPS_ST_IDLE = 4'h2,
    AHPS_ST_LOW  = 4'h4,
    AHPS_ST_HIGH = 4'h8
  } ahps_state_t;

  // Whole state of the block
  typedef struct packed {
    logic [2:0]  sclk_s;
    logic [2:0]  cs_s;
    logic [1:0]  din_s;
    logic [2:0]  mclk_s;
    logic [1:0]  syn_s;
    logic [11:0] sy_cnt;
    logic        sy_low;
    logic        sync_pulse;
    logic        dev_reset;
    logic [31:0] sh_in;
    logic [31:0] sh_out;
    logic [5:0]  bit_cnt;
    logic [31:0] rx_word;
    logic        rx_valid;
    logic        dout;
    logic        oe_n;
    logic [15:0] tmo_cnt;
    logic [15:0] por_cnt;
    logic [15:0] acq_cnt;
    logic        regs_loaded;
    ahps_state_t st;
    logic [2:0]  ph_cnt;
    logic        ready_n;
  } ahps_regs_t;

endpackage : ahps_pkg

// ### rtl/ahps_host_port.sv
// Host port of a multichannel converter: sync/reset sorting, sample-ready pulses,
// start-up latency and the serial slave (clock idle low, second-edge sampling).
// Assumes all pins are asynchronous to sys_clk_i and far slower than it.
`timescale 1ns/10ps
module ahps_host_port #(
  parameter int WORD_W          = ahps_pkg::AHPS_WORD_W,
  parameter int POR_CYCLES      = ahps_pkg::AHPS_POR_CYCLES,
  parameter int TIMEOUT_PERIODS = ahps_pkg::AHPS_TIMEOUT_PERIODS
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              master_clock_in_i,
  input  wire logic              sync_reset_n_i,
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              din_i,
  output logic                   dout_o,
  output logic                   dout_oe_n_o,
  output logic                   sample_ready_n_o,
  input  wire logic [WORD_W-1:0] tx_word_i,
  input  wire logic              data_valid_i,
  output logic [WORD_W-1:0]      rx_word_o,
  output logic                   rx_valid_o,
  output logic                   sync_pulse_o,
  output logic                   device_reset_o,
  output logic                   regs_loaded_o
);

  // Refuse settings the counters cannot hold
  if (WORD_W < 2 || WORD_W > 32) begin : g_chk_word
    $error("WORD_W must be 2 to 32");
  end
  if (POR_CYCLES < 2 || POR_CYCLES > 65535) begin : g_chk_por
    $error("POR_CYCLES must be 2 to 65535");
  end
  if (TIMEOUT_PERIODS < 2 || TIMEOUT_PERIODS > 65535) begin : g_chk_tmo
    $error("TIMEOUT_PERIODS must be 2 to 65535");
  end

  localparam logic [15:0] POR_LAST = 16'(POR_CYCLES - 1);
  localparam logic [15:0] ACQ_LAST = 16'(ahps_pkg::AHPS_REGACQ_CYCLES - 1);
  localparam logic [15:0] TMO_LAST = 16'(TIMEOUT_PERIODS - 1);
  localparam logic [5:0]  BIT_LAST = 6'(WORD_W - 1);
  localparam int          S        = ahps_pkg::AHPS_SYN_STABLE;
  localparam int          P        = ahps_pkg::AHPS_SYN_PREV;

  ahps_pkg::ahps_regs_t r_reg;
  ahps_pkg::ahps_regs_t r_next;

  logic sclk_rise;
  logic sclk_fall;
  logic mclk_rise;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic full_reset;

  // Edges are taken only from stable and previous stages
  assign sclk_rise = r_reg.sclk_s[S] & ~r_reg.sclk_s[P];
  assign sclk_fall = ~r_reg.sclk_s[S] & r_reg.sclk_s[P];
  assign mclk_rise = r_reg.mclk_s[S] & ~r_reg.mclk_s[P];
  assign cs_fall   = ~r_reg.cs_s[S] & r_reg.cs_s[P];
  assign cs_rise   = r_reg.cs_s[S] & ~r_reg.cs_s[P];
  assign cs_low    = ~r_reg.cs_s[S];
  assign full_reset = mclk_rise & ~r_reg.syn_s[S] & ~r_reg.sy_low
                    & (r_reg.sy_cnt == ahps_pkg::AHPS_RESET_LEN - 12'h001);

  always_comb begin
    r_next = r_reg;
    r_next.sync_pulse = 1'b0;
    r_next.dev_reset  = 1'b0;
    r_next.rx_valid   = 1'b0;

    // Two-stage synchronisers plus previous copy for edge finding
    r_next.sclk_s = {r_reg.sclk_s[1:0], sclk_i};
    r_next.cs_s   = {r_reg.cs_s[1:0], cs_n_i};
    r_next.din_s  = {r_reg.din_s[0], din_i};
    r_next.mclk_s = {r_reg.mclk_s[1:0], master_clock_in_i};
    r_next.syn_s  = {r_reg.syn_s[0], sync_reset_n_i};

    // Pulse length measured in whole master periods
    if (mclk_rise) begin
      if (!r_reg.syn_s[S]) begin
        if (r_reg.sy_cnt != ahps_pkg::AHPS_RESET_LEN) begin
          r_next.sy_cnt = r_reg.sy_cnt + 12'h001;
        end
        if (full_reset) begin
          r_next.sy_low    = 1'b1; // Fires once however long the pin stays low
          r_next.dev_reset = 1'b1;
        end
      end else begin
        if (r_reg.sy_cnt >= ahps_pkg::AHPS_SYNC_MIN
            && r_reg.sy_cnt <= ahps_pkg::AHPS_SYNC_MAX) begin
          r_next.sync_pulse = 1'b1;
        end
        r_next.sy_cnt = 12'h000;
        r_next.sy_low = 1'b0;
      end
    end

    // Start-up: power-on delay and register default load
    if (r_reg.por_cnt != POR_LAST) begin
      r_next.por_cnt = r_reg.por_cnt + 16'h0001;
    end
    if (!r_reg.regs_loaded) begin
      if (r_reg.acq_cnt == ACQ_LAST) begin
        r_next.regs_loaded = 1'b1;
      end else begin
        r_next.acq_cnt = r_reg.acq_cnt + 16'h0001;
      end
    end

    // Sample-ready sequencer; phases counted in master periods
    case (r_reg.st)
      ahps_pkg::AHPS_ST_BOOT: begin
        r_next.ready_n = 1'b0;
        if (r_reg.por_cnt == POR_LAST && r_reg.regs_loaded) begin
          r_next.ready_n = 1'b1;
          r_next.ph_cnt  = 3'h0;
          r_next.st      = ahps_pkg::AHPS_ST_HIGH;
        end
      end
      ahps_pkg::AHPS_ST_IDLE: begin
        if (data_valid_i) begin
          r_next.ready_n = 1'b0;
          r_next.ph_cnt  = 3'h0;
          r_next.st      = ahps_pkg::AHPS_ST_LOW;
        end
      end
      ahps_pkg::AHPS_ST_LOW: begin
        if (mclk_rise) begin
          r_next.ph_cnt = r_reg.ph_cnt + 3'h1;
          if (r_reg.ph_cnt == ahps_pkg::AHPS_READY_LOW - 3'h1) begin
            r_next.ready_n = 1'b1;
            r_next.ph_cnt  = 3'h0;
            r_next.st      = ahps_pkg::AHPS_ST_HIGH;
          end
        end
      end
      ahps_pkg::AHPS_ST_HIGH: begin
        if (mclk_rise) begin
          r_next.ph_cnt = r_reg.ph_cnt + 3'h1;
          if (r_reg.ph_cnt == ahps_pkg::AHPS_READY_HIGH - 3'h1) begin
            r_next.ph_cnt = 3'h0;
            r_next.st     = ahps_pkg::AHPS_ST_IDLE;
          end
        end
      end
      default: begin
        r_next.st = ahps_pkg::AHPS_ST_BOOT;
      end
    endcase

    // Output enable follows select; high impedance outside frames
    r_next.oe_n = ~cs_low;

    // Serial slave, mode zero polarity, second-edge sampling
    if (!cs_low) begin
      r_next.bit_cnt = 6'h00;
      r_next.tmo_cnt = 16'h0000;
    end else begin
      if (cs_fall) begin
        // Relies on the host moving select with clock low and before first rise
        r_next.sh_out  = 32'(tx_word_i) << (32 - WORD_W);
        r_next.bit_cnt = 6'h00;
        r_next.tmo_cnt = 16'h0000;
        r_next.dout    = tx_word_i[WORD_W-1];
      end
      if (sclk_rise) begin
        r_next.dout   = r_reg.sh_out[31];
        r_next.sh_out = {r_reg.sh_out[30:0], 1'b0};
      end
      if (sclk_fall) begin
        r_next.sh_in   = {r_reg.sh_in[30:0], r_reg.din_s[S]};
        r_next.bit_cnt = r_reg.bit_cnt + 6'h01;
        if (r_reg.bit_cnt == BIT_LAST) begin
          r_next.rx_word  = {r_reg.sh_in[30:0], r_reg.din_s[S]};
          r_next.rx_valid = 1'b1;
          r_next.bit_cnt  = 6'h00;
          r_next.tmo_cnt  = 16'h0000;
          r_next.sh_out   = 32'(tx_word_i) << (32 - WORD_W); // Next word of a long frame
        end
      end
      // Partial frame that stalls is thrown away
      if (mclk_rise && r_reg.bit_cnt != 6'h00) begin
        r_next.tmo_cnt = r_reg.tmo_cnt + 16'h0001;
        if (r_reg.tmo_cnt == TMO_LAST) begin
          r_next.bit_cnt = 6'h00;
          r_next.tmo_cnt = 16'h0000;
        end
      end
    end

    // Full reset restarts start-up and drops the serial state
    if (full_reset) begin
      r_next.por_cnt     = 16'h0000;
      r_next.acq_cnt     = 16'h0000;
      r_next.regs_loaded = 1'b0;
      r_next.st          = ahps_pkg::AHPS_ST_BOOT;
      r_next.ready_n     = 1'b0;
      r_next.ph_cnt      = 3'h0;
      r_next.bit_cnt     = 6'h00;
      r_next.tmo_cnt     = 16'h0000;
    end
  end

  // Single state register; constants only under reset
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_reg <= '0;
      r_reg.sclk_s <= 3'h0;
      r_reg.cs_s   <= 3'h7; // Select idles high
      r_reg.syn_s  <= 2'h3; // Sync pin idles high
      r_reg.oe_n   <= 1'b1;
      r_reg.st     <= ahps_pkg::AHPS_ST_BOOT;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign dout_o           = r_reg.dout;
  assign dout_oe_n_o      = r_reg.oe_n;
  assign sample_ready_n_o = r_reg.ready_n;
  assign rx_word_o        = r_reg.rx_word[WORD_W-1:0];
  assign rx_valid_o       = r_reg.rx_valid;
  assign sync_pulse_o     = r_reg.sync_pulse;
  assign device_reset_o   = r_reg.dev_reset;
  assign regs_loaded_o    = r_reg.regs_loaded;

endmodule // ahps_host_port

// ### test/ahps_host_port_monitor.sv
// Checker on the host port pins.
// Assumes slow pins; master period of 8 cycles.
`timescale 1ns/10ps
module ahps_host_port_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic sync_reset_n_i,
  input wire logic cs_n_i,
  input wire logic dout_oe_n_o,
  input wire logic sample_ready_n_o,
  input wire logic rx_valid_o,
  input wire logic sync_pulse_o,
  input wire logic device_reset_o,
  input wire logic regs_loaded_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Eight cycles cover the pin synchroniser
  chk_oe_idle: assert property (cs_n_i [*8] |-> dout_oe_n_o)
    else $error("dout driven idle");
  chk_oe_frame: assert property ((!cs_n_i) [*8] |-> !dout_oe_n_o)
    else $error("dout off in frame");
  // Phases span four master periods, well over 8 cycles
  chk_rdy_low: assert property ($fell(sample_ready_n_o) |=> (!sample_ready_n_o) [*8])
    else $error("ready low short");
  chk_rdy_high: assert property ($rose(sample_ready_n_o) |=> sample_ready_n_o [*8])
    else $error("ready high short");
  chk_rdy_load: assert property ($rose(sample_ready_n_o) |-> regs_loaded_o)
    else $error("ready before load");
  chk_sync_pin: assert property (sync_pulse_o |-> sync_reset_n_i && !device_reset_o)
    else $error("bad sync pulse");
  chk_rst_one: assert property (device_reset_o |=> !device_reset_o)
    else $error("reset pulse long");
  chk_rx_one: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("rx pulse long");
  // Main scenarios
  cover property (sync_pulse_o);
  cover property (device_reset_o);
  cover property (rx_valid_o);
endmodule // ahps_host_port_monitor

// ### test/ahps_host_model.sv
// Host model: serial master, clock idle low.
// Assumes the bench clock; half link period 16 cycles.
`timescale 1ns/10ps
module ahps_host_model (
  input  wire logic sys_clk_i,
  input  wire logic dout_i,
  input  wire logic dout_oe_n_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o
);
  // Idle levels before the first frame
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end
  // Half of the 160 ns link period
  task automatic tick();
    repeat (16) @(posedge sys_clk_i);
    #1;
  endtask
  // Select moves with the clock low only
  task automatic sel(input logic v);
    tick();
    cs_n_o = v;
    tick();
  endtask
  // Data on rise, dout taken on fall
  task automatic bits(input int n, input logic [23:0] d, output logic [23:0] q);
    q = 24'h0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b1;
      din_o = d[i];
      tick();
      sclk_o = 1'b0;
      q = {q[22:0], dout_oe_n_i ? ~dout_i : dout_i}; // No pull: undriven line reads wrong
      tick();
    end
    din_o = ~din_o; // Released line must not hold
  endtask
endmodule // ahps_host_model

// ### test/ahps_host_port_tb_top.sv
// Bench: start-up, sample-ready, frames, sync and reset.
// Assumes host model and monitor compiled first.
`timescale 1ns/10ps
module ahps_host_port_tb_top;
  localparam int W = 24;
  logic         sys_clk_i;
  logic         rst_b_i;
  logic         master_clock_in_i;
  logic         sync_reset_n_i;
  logic         data_valid_i;
  logic [W-1:0] tx_word_i;
  logic [W-1:0] rx_word_o, got;
  logic         sclk_i, cs_n_i, din_i, dout_o, dout_oe_n_o, sample_ready_n_o;
  logic         rx_valid_o, sync_pulse_o, device_reset_o, regs_loaded_o;
  int           error_cnt = 0, n_tests = 0, n_sync = 0, n_rst = 0, cyc = 0;
  int           len[4] = '{1, 2, 2047, 2048};
  // Timeout must outlast one whole word (about 96 master periods here)
  ahps_host_port #(.POR_CYCLES(200), .TIMEOUT_PERIODS(128)) ahps_host_port_i (
    .sys_clk_i, .rst_b_i, .master_clock_in_i, .sync_reset_n_i, .sclk_i, .cs_n_i,
    .din_i, .dout_o, .dout_oe_n_o, .sample_ready_n_o, .tx_word_i, .data_valid_i,
    .rx_word_o, .rx_valid_o, .sync_pulse_o, .device_reset_o, .regs_loaded_o);
  ahps_host_model ahps_host_model_i (.sys_clk_i, .dout_i(dout_o), .dout_oe_n_i(dout_oe_n_o),
    .sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i));
  // Clocks; master period is 8 system cycles
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  initial forever begin
    repeat (4) @(posedge sys_clk_i);
    #1 master_clock_in_i = ~master_clock_in_i;
  end
  // Pulse tallies and hang guard
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (sync_pulse_o === 1'b1) n_sync <= n_sync + 1;
    if (device_reset_o === 1'b1) n_rst <= n_rst + 1;
    if (rx_valid_o === 1'b1) got <= rx_word_o;
    if (cyc == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %0h vs %0h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Wait n edges, then step off the edge
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Pin low across n master rises, moved mid-period
  task automatic pin_low(input int n);
    @(posedge master_clock_in_i);
    wt(2);
    sync_reset_n_i = 1'b0;
    repeat (n) @(posedge master_clock_in_i);
    wt(2);
    sync_reset_n_i = 1'b1;
    wt(40);
  endtask
  task automatic phase_len(input logic v, output int n);
    n = 0;
    while (sample_ready_n_o === v && n < 99) begin
      wt(1);
      n++;
    end
  endtask
  // Optional stale prefix, aborted or left to time out
  task automatic frame(input int pre, input int gap);
    logic [W-1:0] w, q;
    w = W'($urandom);
    tx_word_i = W'($urandom);
    ahps_host_model_i.sel(1'b0);
    ahps_host_model_i.bits(pre, ~w, q);
    if (gap == 0 && pre > 0) begin
      ahps_host_model_i.sel(1'b1);
      ahps_host_model_i.sel(1'b0);
    end
    wt(gap);
    ahps_host_model_i.bits(W, w, q);
    ahps_host_model_i.sel(1'b1);
    chk_val(got, w);
    if (gap == 0) chk_val(q, tx_word_i);
  endtask
  initial begin
    int n;
    rst_b_i = 1'b0;
    master_clock_in_i = 1'b0;
    sync_reset_n_i = 1'b1;
    data_valid_i = 1'b0;
    tx_word_i = 24'h000000;
    void'($urandom(13211));
    wt(12);
    rst_b_i = 1'b1;
    wt(990);
    chk_val(regs_loaded_o, 32'h0);
    chk_val(sample_ready_n_o, 32'h0);
    wt(20);
    chk_val(regs_loaded_o, 32'h1);
    chk_val(sample_ready_n_o, 32'h1);
    // Strobe held: next low phase waits out the high one
    wt(60);
    data_valid_i = 1'b1;
    wt(2);
    phase_len(1'b0, n);
    chk_val(n inside {[22:34]}, 32'h1);
    phase_len(1'b1, n);
    chk_val(n inside {[22:36]}, 32'h1);
    data_valid_i = 1'b0;
    repeat (3) frame(0, 0);
    frame(10, 0);
    frame(10, 1100);
    // Lengths either side of the reset threshold
    len[1] = 2 + ($urandom % 20);
    foreach (len[k]) begin
      n = n_sync;
      pin_low(len[k]);
      chk_val(n_sync - n, (len[k] < 2048) ? 32'h1 : 32'h0);
      chk_val(n_rst, (len[k] < 2048) ? 32'h0 : 32'h1);
    end
    chk_val(regs_loaded_o, 32'h0);
    wt(1100);
    chk_val(sample_ready_n_o, 32'h1);
    give_verdict();
  end
endmodule // ahps_host_port_tb_top
bind ahps_host_port ahps_host_port_monitor ahps_host_port_monitor_i (.sys_clk_i, .rst_b_i,
  .sync_reset_n_i, .cs_n_i, .dout_oe_n_o, .sample_ready_n_o, .rx_valid_o, .sync_pulse_o,
  .device_reset_o, .regs_loaded_o);
